// ===== xpc_pkg.sv
// Package with register map, field positions and reset values of the expansion port block
package xpc_pkg;
    // Register indices and byte addresses (index times four)
    localparam logic [7:0] ADDR_PORT_CFG   = 8'h83;           // Port enable, clock mode, ready sel
    localparam logic [7:0] ADDR_PORT_FMT   = 8'h92;           // Code, clock sel, ref config
    localparam logic [9:0] OFS_PORT_CFG    = 10'h20c;         // 83H times four
    localparam logic [9:0] OFS_PORT_FMT    = 10'h248;         // 92H times four
    localparam logic [9:0] OFS_PORT_STAT   = 10'h300;         // Status word
    localparam logic [9:0] OFS_PORT_VIDEO  = 10'h304;         // Output video word
    // Field positions in 83H
    localparam int POS_PORT_ENABLE = 0;                       // Two bits
    localparam int POS_READY_TASK  = 2;
    localparam int POS_CLOCK_MODE  = 4;                       // Two bits
    // Field positions in 92H
    localparam int POS_CLOCK_SEL   = 0;
    localparam int POS_QUAL_CFG    = 1;
    localparam int POS_HOR_CFG     = 2;
    localparam int POS_CODE_SEL    = 3;
    localparam int POS_VERT_CFG    = 4;                       // Two bits
    localparam int POS_WIDE_MODE   = 6;                       // 16-bit input mode
    // Reset values
    localparam logic [7:0] RST_PORT_CFG    = 8'h00;
    localparam logic [7:0] RST_PORT_FMT    = 8'h00;
    localparam logic [7:0] RST_VIDEO       = 8'h00;
endpackage

// ===== xpc_port.sv
// Expansion port pin function and direction control with APB register access
// Overview
// Two clock domains meet here. The bus side runs on pclk and holds the
// two configuration images, the output video byte and the ready pin.
// The link side runs on the line-locked clock and owns every port pin
// except the ready pin, which follows pclk-domain status levels.
// Configuration crosses into the link domain through two flops per bit.
// This is safe only because software changes these bits rarely; a
// multi-bit field may show a mixed value for one link cycle after a write.
// Captured input bytes cross back by a toggle and a three-stage shifter,
// so at most one byte per few pclk cycles reaches the bus side; a faster
// byte stream overwrites the holding register and only the last survives.
// The output-enable pin is asynchronous and passes three flops; a change
// counts once the second and third stages agree, which rejects glitches.
//
// Limitations
// No buffering: an unread byte is lost once the next one is captured.
// Reference inputs from the far side are not used by the logic yet.
`timescale 1ns/1ps

module xpc_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_clk,
    input  wire logic        port_output_enable_pin,
    input  wire logic        task_b_active,
    input  wire logic        input_ready,
    input  wire logic        dec_hor_ref,
    input  wire logic        dec_vert_ref,
    input  wire logic [7:0]  port_data_lines_in,
    output logic      [7:0]  port_data_lines_out,
    output logic      [7:0]  port_data_lines_oe,
    input  wire logic        port_clock_pin_in,
    output logic             port_clock_pin_out,
    output logic             port_clock_pin_oe,
    input  wire logic        port_qualifier_pin_in,
    output logic             port_qualifier_pin_out,
    output logic             port_qualifier_pin_oe,
    output logic             port_ready_pin_out,
    output logic             port_ready_pin_oe,
    input  wire logic        port_hor_ref_pin_in,
    output logic             port_hor_ref_pin_out,
    output logic             port_hor_ref_pin_oe,
    input  wire logic        port_vert_ref_pin_in,
    output logic             port_vert_ref_pin_out,
    output logic             port_vert_ref_pin_oe,
    output logic      [7:0]  captured_data,
    output logic             captured_valid
);

    // Bus-side state, all in one struct
    // Everything clocked by pclk lives here so that one process
    // registers it and one process computes its next value.
    // Reset values of the register images come from the package;
    // the rest clears to zero, which leaves every pin tri-stated.
    typedef struct packed {
        logic [7:0]  port_cfg;      // 83H image
        logic [7:0]  port_fmt;      // 92H image
        logic [7:0]  video_out;     // Byte driven on the data lines
        logic [31:0] rdata;         // Read data
        logic        ready;         // APB ready
        logic        slverr;        // APB error
        logic [2:0]  oe_sync;       // Output enable pin synchroniser
        logic        oe_level;      // Filtered pin level
        logic [2:0]  cap_tog_sync;  // Capture toggle synchroniser
        logic [7:0]  cap_data;      // Captured input byte
        logic        cap_valid;     // One-cycle capture strobe
        logic        data_oe;       // Data lines drive
        logic        ctl_oe;        // Control pins drive
        logic        rdy_out;       // Ready pin value
    } xpc_bus_type;

    // Link-side state
    // Everything clocked by the line-locked clock lives here.
    // The s1 and s2 fields form the synchronisers of settings that
    // come from the bus side; only the s2 copies are used by logic.
    typedef struct packed {
        logic [7:0] cfg_s1;         // First stage of config crossing
        logic [7:0] cfg_s2;         // Settled config copy
        logic [7:0] vid_s1;         // Video byte first stage
        logic [7:0] vid_s2;         // Video byte settled
        logic [3:0] drv_s1;         // Drive enables first stage
        logic [3:0] drv_s2;         // Drive enables settled
        logic [7:0] data_out;       // Data lines out
        logic       clk_out;        // Clock pin out
        logic       qual_out;       // Qualifier out
        logic       hor_out;        // Horizontal reference out
        logic       vert_out;       // Vertical reference out
        logic       vert_prev;      // Edge detect for pulse mode
        logic [7:0] in_byte;        // Last accepted input byte
        logic       in_tog;         // Toggles per accepted byte
        logic       div;            // Divider for driven clock
    } xpc_link_type;

    xpc_bus_type  b_ff, nxt_b;
    xpc_link_type l_ff, nxt_l;

    // Field views of the bus-side registers
    // Named slices keep the decode readable and tie each use
    // to one field position of the package.
    logic [1:0] port_enable_field;
    logic       ready_task_select;
    logic [1:0] port_clock_mode_field;
    logic       port_clock_select_bit;
    logic       port_code_select;
    logic       wide_mode;
    logic       apb_setup;
    logic [9:0] ofs;

    assign port_enable_field     = b_ff.port_cfg[xpc_pkg::POS_PORT_ENABLE +: 2];
    assign ready_task_select     = b_ff.port_cfg[xpc_pkg::POS_READY_TASK];
    assign port_clock_mode_field = b_ff.port_cfg[xpc_pkg::POS_CLOCK_MODE +: 2];
    assign port_clock_select_bit = b_ff.port_fmt[xpc_pkg::POS_CLOCK_SEL];
    assign port_code_select      = b_ff.port_fmt[xpc_pkg::POS_CODE_SEL];
    assign wide_mode             = b_ff.port_fmt[xpc_pkg::POS_WIDE_MODE];
    assign apb_setup             = psel && !penable;
    assign ofs                   = paddr[9:0];

    // Bus-side next state: APB slave, no wait state, plus drive decisions
    // The slave answers every transfer in its first access cycle:
    // setup at one edge, ready high for the next cycle, done.
    // Read data is captured at the setup edge, so a read of the status
    // word shows the state one cycle before the access completes.
    // A write lands at the edge that completes the access and only
    // when no error was flagged for it; erroring writes change nothing.
    always_comb begin
        nxt_b = b_ff;
        nxt_b.ready     = 1'b0;
        nxt_b.slverr    = 1'b0;
        nxt_b.cap_valid = 1'b0;
        // Answer in access phase one cycle after setup
        if (apb_setup) begin
            nxt_b.ready = 1'b1;
            nxt_b.rdata = 32'h0;
            case (ofs)
                xpc_pkg::OFS_PORT_CFG:  nxt_b.rdata = {24'h0, b_ff.port_cfg};
                xpc_pkg::OFS_PORT_FMT:  nxt_b.rdata = {24'h0, b_ff.port_fmt};
                xpc_pkg::OFS_PORT_VIDEO: nxt_b.rdata = {24'h0, b_ff.video_out};
                xpc_pkg::OFS_PORT_STAT: nxt_b.rdata = {22'h0, b_ff.ctl_oe, b_ff.data_oe,
                                                       b_ff.cap_data};
                default: nxt_b.slverr = 1'b1;   // Unmapped address errors
            endcase
            if (paddr[11:10] != 2'b00) begin
                nxt_b.slverr = 1'b1;
            end
        end
        // Writes take effect at the completing edge
        if (psel && penable && b_ff.ready && pwrite && !b_ff.slverr) begin
            case (ofs)
                xpc_pkg::OFS_PORT_CFG:   nxt_b.port_cfg  = pwdata[7:0];
                xpc_pkg::OFS_PORT_FMT:   nxt_b.port_fmt  = pwdata[7:0];
                xpc_pkg::OFS_PORT_VIDEO: nxt_b.video_out = pwdata[7:0];
                default: ;              // Status is read only
            endcase
        end
        // Pin level counts once second and third stages agree
        nxt_b.oe_sync = {b_ff.oe_sync[1:0], port_output_enable_pin};
        if (b_ff.oe_sync[1] == b_ff.oe_sync[2]) begin
            nxt_b.oe_level = b_ff.oe_sync[2];
        end
        // enable combines field and pin
        // Field 00 tri-states all, 01 follows pin (low enables), 1x drives always
        case (port_enable_field)
            2'b00:   nxt_b.ctl_oe = 1'b0;
            2'b01:   nxt_b.ctl_oe = !b_ff.oe_level;
            default: nxt_b.ctl_oe = 1'b1;
        endcase
        // data lines drive only in output code
        // Wide mode forces input: luma arrives on these lines
        nxt_b.data_oe = nxt_b.ctl_oe && port_code_select && !wide_mode;
        nxt_b.rdy_out = ready_task_select ? task_b_active : input_ready;
        // Accepted byte crosses by toggle; data is stable a full byte time
        nxt_b.cap_tog_sync = {b_ff.cap_tog_sync[1:0], l_ff.in_tog};
        if (b_ff.cap_tog_sync[2] != b_ff.cap_tog_sync[1]) begin
            nxt_b.cap_data  = l_ff.in_byte;
            nxt_b.cap_valid = 1'b1;
        end
    end

    // Bus-side registers
    // Asynchronous reset: all pins tri-state at once, without waiting
    // for a clock edge, so a stuck clock cannot leave the port driving.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_ff <= '0;
            b_ff.port_cfg  <= xpc_pkg::RST_PORT_CFG;
            b_ff.port_fmt  <= xpc_pkg::RST_PORT_FMT;
            b_ff.video_out <= xpc_pkg::RST_VIDEO;
        end else begin
            b_ff <= nxt_b;
        end
    end

    // Link-side next state: pin functions on the line-locked clock
    // Pin outputs are registered once on the link clock so they change
    // only on that clock and never glitch between its edges.
    // The driven clock is made by logic and is therefore a data signal;
    // a receiver should sample data on the opposite edge of it.
    // Input bytes are accepted only while the data lines are not driven,
    // so the block never captures its own output.
    always_comb begin
        logic qual_gate;
        logic clk_drive;
        qual_gate = 1'b0;
        clk_drive = 1'b0;
        nxt_l = l_ff;
        // Quasi-static settings pass two flops into the link domain
        nxt_l.cfg_s1 = {b_ff.port_fmt[5:0], port_clock_mode_field};
        nxt_l.cfg_s2 = l_ff.cfg_s1;
        nxt_l.vid_s1 = b_ff.video_out;
        nxt_l.vid_s2 = l_ff.vid_s1;
        nxt_l.drv_s1 = {b_ff.data_oe, b_ff.ctl_oe, b_ff.data_oe, b_ff.ctl_oe};
        nxt_l.drv_s2 = l_ff.drv_s1;
        nxt_l.div    = !l_ff.div;
        nxt_l.hor_out = dec_hor_ref ^ l_ff.cfg_s2[2 + xpc_pkg::POS_HOR_CFG];
        // vertical reference, field picks level, pulse or inverted
        case (l_ff.cfg_s2[2 + xpc_pkg::POS_VERT_CFG +: 2])
            2'b00:   nxt_l.vert_out = dec_vert_ref;
            2'b01:   nxt_l.vert_out = !dec_vert_ref;
            2'b10:   nxt_l.vert_out = dec_vert_ref && !l_ff.vert_prev;
            default: nxt_l.vert_out = !dec_vert_ref && l_ff.vert_prev;
        endcase
        nxt_l.vert_prev = dec_vert_ref;
        // qualifier is a gate of both references
        qual_gate = dec_hor_ref && dec_vert_ref;
        nxt_l.qual_out = qual_gate ^ l_ff.cfg_s2[2 + xpc_pkg::POS_QUAL_CFG];
        // driven clock, select bit picks halved or a constant level
        clk_drive = l_ff.cfg_s2[2 + xpc_pkg::POS_CLOCK_SEL] ? l_ff.div : 1'b1;
        nxt_l.clk_out = clk_drive ^ l_ff.cfg_s2[1];
        nxt_l.data_out = l_ff.vid_s2;
        // gated clock mode also needs qualifier
        if (!l_ff.drv_s2[3]
            && (port_qualifier_pin_in || !l_ff.cfg_s2[0])
            && port_clock_pin_in) begin
            nxt_l.in_byte = port_data_lines_in;
            nxt_l.in_tog  = !l_ff.in_tog;
        end
    end

    // Link-side registers
    // Same reset as the bus side; it must be held long enough to
    // cover at least two edges of the slower link clock.
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            l_ff <= '0;
        end else begin
            l_ff <= nxt_l;
        end
    end

    // Outputs from flops only
    // Each pin value and enable comes straight from a register of the
    // domain that owns it, so no decode glitch ever reaches a pad.
    // The three reference-type pins share one enable; the data lines
    // add the code and width conditions on top of it.
    assign prdata                 = b_ff.rdata;
    assign pready                 = b_ff.ready;
    assign pslverr                = b_ff.slverr;
    assign port_data_lines_out    = l_ff.data_out;
    assign port_data_lines_oe     = {8{l_ff.drv_s2[1]}};
    assign port_clock_pin_out     = l_ff.clk_out;
    assign port_clock_pin_oe      = l_ff.drv_s2[0];
    assign port_qualifier_pin_out = l_ff.qual_out;
    assign port_qualifier_pin_oe  = l_ff.drv_s2[2];
    assign port_ready_pin_out     = b_ff.rdy_out;
    assign port_ready_pin_oe      = b_ff.ctl_oe;
    assign port_hor_ref_pin_out   = l_ff.hor_out;
    assign port_hor_ref_pin_oe    = l_ff.drv_s2[2];
    assign port_vert_ref_pin_out  = l_ff.vert_out;
    assign port_vert_ref_pin_oe   = l_ff.drv_s2[2];
    assign captured_data          = b_ff.cap_data;
    assign captured_valid         = b_ff.cap_valid;

endmodule

// ===== xpc_port_monitor.sv
// Checker of bus timing and pin enables of the expansion port
`timescale 1ns/1ps
module xpc_port_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  port_data_lines_oe,
    input wire logic        port_ready_pin_oe,
    input wire logic        captured_valid,
    input wire logic        link_clk,
    input wire logic        dec_hor_ref,
    input wire logic        dec_vert_ref,
    input wire logic        port_hor_ref_pin_out,
    input wire logic        port_qualifier_pin_out
);
    logic [7:0] cfg_ff;  // Shadow of the enable register
    logic [7:0] fmt_ff;  // Shadow of the format register
    logic [4:0] age_ff;  // Cycles since any write, saturating
    wire        wr = psel && penable && pready && pwrite;
    // Shadows let pin checks wait out the clock crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= 8'h00;
            fmt_ff <= 8'h00;
            age_ff <= 5'h00;
        end else begin
            if (wr && paddr == 12'h20c) cfg_ff <= pwdata[7:0];
            if (wr && paddr == 12'h248) fmt_ff <= pwdata[7:0];
            age_ff <= wr ? 5'h00 : (age_ff == 5'h1f ? age_ff : age_ff + 5'h01);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    a_high_addr_err: assert property (psel && !penable && paddr[11:10] != 2'b00 |=> pslverr)
        else $error("high address not refused");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:10] == 22'h0)
        else $error("upper read bits set");
    a_data_tri: assert property (age_ff >= 5'h14 && (cfg_ff[1:0] == 2'b00 || fmt_ff[6]
        || !fmt_ff[3]) |-> port_data_lines_oe == 8'h00)
        else $error("data lines driven while off");
    a_data_drive: assert property (age_ff >= 5'h14 && cfg_ff[1] && fmt_ff[3] && !fmt_ff[6]
        |-> port_data_lines_oe == 8'hff)
        else $error("data lines not driven");
    a_ready_tri: assert property (age_ff >= 5'h14 && cfg_ff[1:0] == 2'b00
        |-> !port_ready_pin_oe)
        else $error("ready pin driven while off");
    a_ready_drive: assert property (age_ff >= 5'h14 && cfg_ff[1] |-> port_ready_pin_oe)
        else $error("ready pin not driven");
    a_hor_follows: assert property (@(posedge link_clk) age_ff >= 5'h14
        |-> port_hor_ref_pin_out == ($past(dec_hor_ref) ^ fmt_ff[2]))
        else $error("horizontal reference out wrong");
    a_qual_gate: assert property (@(posedge link_clk) age_ff >= 5'h14
        |-> port_qualifier_pin_out == (($past(dec_hor_ref) && $past(dec_vert_ref)) ^ fmt_ff[1]))
        else $error("qualifier gate out wrong");
    a_capture_pulse: assert property (captured_valid |=> !captured_valid)
        else $error("capture flag not a pulse");
endmodule
bind xpc_port xpc_port_monitor mon_u (.*);

// ===== xpc_video_source.sv
// Behavioural video source driving the port pins in input mode
`timescale 1ns/1ps
module xpc_video_source (
    input  wire logic       link_clk,
    input  wire logic       send,
    input  wire logic [7:0] byte_val,
    input  wire logic       dev_drives,
    output logic      [7:0] data_pin = 8'h00,
    output logic            clock_pin = 1'b0,
    output logic            qual_pin = 1'b0,
    output logic            horizontal_reference_pin = 1'b0,
    output logic            vref_pin = 1'b0
);
    // Outside a frame the gate stays low and released lines toggle
    always @(posedge link_clk) begin
        data_pin <= (send && !dev_drives) ? byte_val : ~data_pin;
        clock_pin <= send;
        qual_pin <= send;
        horizontal_reference_pin <= send;
        vref_pin <= !send;
    end
endmodule

// ===== expansion_port_pin_config_test.sv
// Self-checking bench of the expansion port pin control
`timescale 1ns/1ps
module expansion_port_pin_config_test;
    logic        pclk = 1'b0, presetn = 1'b0, link_clk = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, pwd;
    logic        port_output_enable_pin = 1'b1, task_b_active = 1'b0, input_ready = 1'b0;
    logic        dec_hor_ref = 1'b0, dec_vert_ref = 1'b0, send = 1'b0, er, captured_valid;
    logic [7:0]  sbyte = 8'h00, port_data_lines_in, port_data_lines_out;
    logic [7:0]  port_data_lines_oe, captured_data;
    logic        port_clock_pin_in, port_clock_pin_out, port_clock_pin_oe;
    logic        port_qualifier_pin_in, port_qualifier_pin_out, port_qualifier_pin_oe;
    logic        port_ready_pin_out, port_ready_pin_oe, port_hor_ref_pin_in;
    logic        port_hor_ref_pin_out, port_hor_ref_pin_oe, port_vert_ref_pin_in;
    logic        port_vert_ref_pin_out, port_vert_ref_pin_oe;
    int          failures = 0, compares = 0, seed = 32'h56664d8d, n;
    xpc_port dut_u (.*);
    xpc_video_source src_u (.link_clk(link_clk), .send(send), .byte_val(sbyte),
        .dev_drives(|port_data_lines_oe), .data_pin(port_data_lines_in),
        .clock_pin(port_clock_pin_in), .qual_pin(port_qualifier_pin_in),
        .horizontal_reference_pin(port_hor_ref_pin_in), .vref_pin(port_vert_ref_pin_in));
    // Bus clock and an unrelated link clock
    initial forever #4 pclk = ~pclk;
    initial begin
        #3.7;
        forever #15 link_clk = ~link_clk;
    end
    // Decoder references wander at random
    always @(posedge link_clk) begin
        dec_hor_ref <= $random(seed);
        dec_vert_ref <= $random(seed);
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One APB transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Covers the crossing to the link clock and the pin synchroniser
    task automatic settle;
        repeat (24) @(posedge pclk);
    endtask
    function automatic logic [7:0] exp_oe(logic [1:0] f, logic pin, logic wide);
        return (!wide && (f[1] || (f == 2'b01 && !pin))) ? 8'hff : 8'h00;
    endfunction
    task automatic summarize;
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h248, 32'h0);
        chk("format reset", 32'h0, rd);
        apb(1'b1, 12'h010, $random(seed));
        chk("unmapped error", 32'h1, er);
        repeat (4) begin
            pwd = $random(seed);
            apb(1'b1, 12'h248, pwd);
            apb(1'b0, 12'h248, 32'h0);
            chk("format readback", pwd & 32'h7f, rd & 32'h7f);
        end
        $display("test registers ended");
        // Enable field by pin level by wide mode, code select on
        for (int i = 0; i < 16; i++) begin
            port_output_enable_pin <= i[2];
            apb(1'b1, 12'h248, {25'h0, i[3], 2'b00, 1'b1, 3'b000});
            apb(1'b1, 12'h20c, {30'h0, i[1:0]});
            settle();
            chk("data enable", exp_oe(i[1:0], i[2], i[3]), port_data_lines_oe);
            chk("ready enable", exp_oe(i[1:0], i[2], 1'b0) != 0, port_ready_pin_oe);
            if (i[1:0] == 2'b10) chk("clock out", 32'h1, port_clock_pin_out);
        end
        pwd = $random(seed);
        apb(1'b1, 12'h304, pwd);
        settle();
        chk("video out", pwd[7:0], port_data_lines_out);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, 12'h20c, {29'h0, j[1], 2'b10});
            task_b_active <= j[0];
            input_ready <= !j[0];
            settle();
            chk("ready pin", j[1] ? j[0] : !j[0], port_ready_pin_out);
        end
        $display("test outputs ended");
        // Input capture with and without the qualifier
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h20c, k ? 32'h10 : 32'h0);
            sbyte <= $random(seed);
            settle();
            send <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (captured_valid !== 1'b1 && n < 200);
            chk("captured byte", sbyte, captured_data);
            send <= 1'b0;
            apb(1'b0, 12'h300, 32'h0);
            chk("status", {2'b00, sbyte}, rd[9:0]);
            settle();
        end
        $display("test capture ended");
        summarize();
    end
    initial begin
        #200000;
        failures++;
        summarize();
    end
endmodule
